// ===== hw/lee_engine.sv
// Logic equation engine with APB register access
// Functional notes
// - Each equation takes up to four inputs selected from the signal list.
// - Every gate input has its own invert option.
// - Gate result passes a timer with separate assert and deassert delays.
// - Timer gives a direct delayed signal and a latched copy.
// - Latch set input can be inverted.
// - Latch of an active equation clears only by an assigned reset signal; otherwise it holds.
// - Latch clear input can be inverted.
// - Equations are evaluated in ascending order from the first, pass after pass.
// - Lower equation output reaches a higher equation within the same pass.
// - Higher equation output reaches a lower equation one pass later.
// - Equation outputs and relay signals are all selectable as inputs.
// - Active equation count is 0, 5, 10, 20, 40 or 80, default 20.
// - Input and output states of every equation are readable.
// - Each active equation outputs gate, delayed, latched and inverted latched results.
// - Invert applies only to an input that has a signal assigned.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
module lee_engine #(
	parameter int MAX_EQ = 80,
	parameter int EXT_W  = 32
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [11:0]       paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [EXT_W-1:0]  relay_signals,
	output logic      [MAX_EQ-1:0] gate_result,
	output logic      [MAX_EQ-1:0] delayed_result,
	output logic      [MAX_EQ-1:0] latched_result,
	output logic      [MAX_EQ-1:0] latched_result_n,
	output logic                   pass_done
);
	localparam int SRC_W = 1 + EXT_W + 4 * MAX_EQ;

	lee_pkg::lee_cfg_type            cfg_q [MAX_EQ];
	lee_pkg::lee_obs_type            obs_q [MAX_EQ];
	logic [lee_pkg::LEE_DLY_W-1:0]   cnt_q [MAX_EQ];
	logic [MAX_EQ-1:0]               gate_q;
	logic [MAX_EQ-1:0]               del_q;
	logic [MAX_EQ-1:0]               lat_q;
	logic [MAX_EQ-1:0]               latn_q;
	logic [2:0]                      code_q;
	logic [6:0]                      idx_q;
	logic [15:0]                     pass_q;
	logic                            pass_done_q;
	logic [31:0]                     prdata_q;
	logic                            pready_q;
	logic                            pslverr_q;
	logic [6:0]                      active_n;
	logic                            eval_en;
	logic [SRC_W-1:0]                src_vec;
	lee_pkg::lee_cfg_type            cur;
	logic [3:0]                      lvl;
	logic [3:0]                      asg;
	logic [3:0]                      v;
	logic                            gate_c;
	logic                            del_c;
	logic                            del_cur;
	logic                            lat_cur;
	logic [lee_pkg::LEE_DLY_W-1:0]   cnt_c;
	logic [lee_pkg::LEE_DLY_W-1:0]   dly;
	logic                            clr_lvl;
	logic                            clr_act;
	logic                            set_act;
	logic                            lat_c;
	logic [11:0]                     eq_off;
	logic [6:0]                      eq_c;
	logic [6:0]                      eq_i;
	logic [2:0]                      word_c;
	logic                            eq_hit;
	logic                            hit_c;
	logic [31:0]                     rd_c;
	logic                            acc;
	logic                            wr_en;

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign gate_result      = gate_q;
	assign delayed_result   = del_q;
	assign latched_result   = lat_q;
	assign latched_result_n = latn_q;
	assign pass_done        = pass_done_q;

	assign active_n = lee_pkg::lee_active_n(code_q);
	assign eval_en  = (active_n != 7'h00) && (idx_q < active_n);

	// Relay signals and every equation output form one selectable list
	always_comb begin
		src_vec = '0;
		src_vec[EXT_W:1] = relay_signals;
		for (int e = 0; e < MAX_EQ; e++) begin
			src_vec[1 + EXT_W + 4 * e +: 4] = {latn_q[e], lat_q[e], del_q[e], gate_q[e]};
		end
	end

	// Selection code zero means unassigned and reads low
	function automatic logic pick(input logic [lee_pkg::LEE_SEL_W-1:0] s);
		pick = (int'(s) < SRC_W) ? src_vec[s] : 1'b0;
	endfunction

	always_comb begin
		cur     = cfg_q[idx_q < 7'(MAX_EQ) ? idx_q : 7'h00];
		del_cur = del_q[idx_q];
		lat_cur = lat_q[idx_q];
		for (int j = 0; j < lee_pkg::LEE_NIN; j++) begin
			lvl[j] = pick(cur.sel[j]);
			asg[j] = cur.sel[j] != '0;
			v[j]   = lvl[j] ^ (cur.inv[j] & asg[j]);
		end
		unique case (cur.gate)
			lee_pkg::LEE_AND:  gate_c = &(v | ~asg);
			lee_pkg::LEE_OR:   gate_c = |(v & asg);
			lee_pkg::LEE_NAND: gate_c = ~&(v | ~asg);
			lee_pkg::LEE_NOR:  gate_c = ~|(v & asg);
		endcase
		if (asg == 4'h0) begin
			gate_c = 1'b0;
		end
		dly = gate_c ? cur.on_dly : cur.off_dly;
		if (gate_c == del_cur) begin
			del_c = del_cur;
			cnt_c = '0;
		end else if (cnt_q[idx_q] >= dly) begin
			del_c = gate_c;
			cnt_c = '0;
		end else begin
			del_c = del_cur;
			cnt_c = cnt_q[idx_q] + 16'h0001;
		end
		clr_lvl = pick(cur.clr_sel);
		clr_act = (cur.clr_sel != '0) && (clr_lvl ^ cur.clr_inv);
		set_act = del_c ^ cur.set_inv;
		// Clear dominates so an asserted reset always wins
		lat_c = clr_act ? 1'b0 : (set_act ? 1'b1 : lat_cur);
	end

	// One equation per clock, lowest index first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_q       <= 7'h00;
			pass_q      <= 16'h0000;
			pass_done_q <= 1'b0;
		end else begin
			pass_done_q <= 1'b0;
			if (!eval_en) begin
				idx_q <= 7'h00;
			end else if (idx_q == active_n - 7'h01) begin
				idx_q       <= 7'h00;
				pass_q      <= pass_q + 16'h0001;
				pass_done_q <= 1'b1;
			end else begin
				idx_q <= idx_q + 7'h01;
			end
		end
	end

	// Results stored at once, so later indexes see them this pass, earlier ones next pass
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= '0;
			del_q  <= '0;
			lat_q  <= '0;
			latn_q <= '0;
			for (int i = 0; i < MAX_EQ; i++) begin
				cnt_q[i] <= '0;
				obs_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < MAX_EQ; i++) begin
				if (7'(i) >= active_n) begin
					gate_q[i] <= 1'b0;
					del_q[i]  <= 1'b0;
					lat_q[i]  <= 1'b0;
					latn_q[i] <= 1'b0;
					cnt_q[i]  <= '0;
					obs_q[i]  <= '0;
				end
			end
			if (eval_en) begin
				gate_q[idx_q] <= gate_c;
				del_q[idx_q]  <= del_c;
				lat_q[idx_q]  <= lat_c;
				latn_q[idx_q] <= ~lat_c;
				cnt_q[idx_q]  <= cnt_c;
				obs_q[idx_q]  <= {lvl, clr_lvl};
			end
		end
	end

	// APB decode
	always_comb begin
		eq_off = paddr - lee_pkg::LEE_EQ_BASE;
		eq_c   = eq_off[11:5];
		word_c = eq_off[4:2];
		eq_hit = (paddr >= lee_pkg::LEE_EQ_BASE) && (eq_c < 7'(MAX_EQ)) && (word_c <= lee_pkg::LEE_W_OBS);
		eq_i   = eq_hit ? eq_c : 7'h00;
		hit_c  = eq_hit || (paddr == lee_pkg::LEE_CTRL_OFF) || (paddr == lee_pkg::LEE_STAT_OFF);
		rd_c   = 32'h0000_0000;
		if (paddr == lee_pkg::LEE_CTRL_OFF) begin
			rd_c[2:0] = code_q;
		end else if (paddr == lee_pkg::LEE_STAT_OFF) begin
			rd_c[6:0] = idx_q;
			rd_c[lee_pkg::LEE_PASS_LSB +: 16] = pass_q;
		end else if (eq_hit) begin
			unique case (word_c)
				lee_pkg::LEE_W_SEL01: begin
					rd_c[8:0] = cfg_q[eq_i].sel[0];
					rd_c[lee_pkg::LEE_HI_LSB +: 9] = cfg_q[eq_i].sel[1];
				end
				lee_pkg::LEE_W_SEL23: begin
					rd_c[8:0] = cfg_q[eq_i].sel[2];
					rd_c[lee_pkg::LEE_HI_LSB +: 9] = cfg_q[eq_i].sel[3];
				end
				lee_pkg::LEE_W_MISC: begin
					rd_c[8:0] = cfg_q[eq_i].clr_sel;
					rd_c[lee_pkg::LEE_INV_LSB +: 4] = cfg_q[eq_i].inv;
					rd_c[lee_pkg::LEE_GATE_LSB +: 2] = cfg_q[eq_i].gate;
					rd_c[lee_pkg::LEE_SETINV_BIT] = cfg_q[eq_i].set_inv;
					rd_c[lee_pkg::LEE_CLRINV_BIT] = cfg_q[eq_i].clr_inv;
				end
				lee_pkg::LEE_W_DLY: begin
					rd_c[15:0] = cfg_q[eq_i].on_dly;
					rd_c[lee_pkg::LEE_HI_LSB +: 16] = cfg_q[eq_i].off_dly;
				end
				default: begin
					rd_c[4:0] = obs_q[eq_i];
					rd_c[lee_pkg::LEE_OBS_OUT +: 4] = {latn_q[eq_i], lat_q[eq_i], del_q[eq_i], gate_q[eq_i]};
				end
			endcase
		end
	end

	assign acc   = psel && penable && !pready_q;
	assign wr_en = psel && penable && pready_q && pwrite && hit_c;

	// One wait state keeps read data registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= acc;
			if (acc) begin
				prdata_q  <= pwrite ? 32'h0000_0000 : rd_c;
				pslverr_q <= !hit_c;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_q <= lee_pkg::LEE_COUNT_RST;
		end else if (wr_en && paddr == lee_pkg::LEE_CTRL_OFF) begin
			code_q <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < MAX_EQ; i++) begin
				cfg_q[i] <= lee_pkg::LEE_CFG_RST;
			end
		end else if (wr_en && eq_hit) begin
			unique case (word_c)
				lee_pkg::LEE_W_SEL01: begin
					cfg_q[eq_i].sel[0] <= pwdata[8:0];
					cfg_q[eq_i].sel[1] <= pwdata[lee_pkg::LEE_HI_LSB +: 9];
				end
				lee_pkg::LEE_W_SEL23: begin
					cfg_q[eq_i].sel[2] <= pwdata[8:0];
					cfg_q[eq_i].sel[3] <= pwdata[lee_pkg::LEE_HI_LSB +: 9];
				end
				lee_pkg::LEE_W_MISC: begin
					cfg_q[eq_i].clr_sel <= pwdata[8:0];
					cfg_q[eq_i].inv     <= pwdata[lee_pkg::LEE_INV_LSB +: 4];
					cfg_q[eq_i].gate    <= lee_pkg::lee_gate_type'(pwdata[lee_pkg::LEE_GATE_LSB +: 2]);
					cfg_q[eq_i].set_inv <= pwdata[lee_pkg::LEE_SETINV_BIT];
					cfg_q[eq_i].clr_inv <= pwdata[lee_pkg::LEE_CLRINV_BIT];
				end
				lee_pkg::LEE_W_DLY: begin
					cfg_q[eq_i].on_dly  <= pwdata[15:0];
					cfg_q[eq_i].off_dly <= pwdata[lee_pkg::LEE_HI_LSB +: 16];
				end
				default: begin
				end
			endcase
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_order;
		eval_en && (idx_q != active_n - 7'h01) |=> idx_q == $past(idx_q) + 7'h01;
	endproperty
	a_order: assert property (p_order) else $error("index did not advance by one");

	property p_wrap;
		eval_en && (idx_q == active_n - 7'h01) |=> (idx_q == 7'h00) && pass_done_q;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pass did not restart at first equation");

	property p_clear;
		eval_en && clr_act |=> !lat_q[$past(idx_q)] && latn_q[$past(idx_q)];
	endproperty
	a_clear: assert property (p_clear) else $error("latch not cleared");

	property p_set;
		eval_en && set_act && !clr_act |=> lat_q[$past(idx_q)];
	endproperty
	a_set: assert property (p_set) else $error("latch not set");

	property p_unasg;
		eval_en && (cur.sel == '0) && (cur.inv != 4'h0) |=> !gate_q[$past(idx_q)];
	endproperty
	a_unasg: assert property (p_unasg) else $error("unassigned inputs drove gate");

	property p_ondly;
		eval_en && gate_c && !del_cur && (cur.on_dly == 16'h0000) |=> del_q[$past(idx_q)];
	endproperty
	a_ondly: assert property (p_ondly) else $error("zero assert delay not immediate");

	property p_hold;
		eval_en && (gate_c != del_cur) && (cnt_q[idx_q] < dly) |=> del_q[$past(idx_q)] == $past(del_cur);
	endproperty
	a_hold: assert property (p_hold) else $error("delayed result changed early");

	property p_comp;
		eval_en |=> latn_q[$past(idx_q)] != lat_q[$past(idx_q)];
	endproperty
	a_comp: assert property (p_comp) else $error("inverted latch not complement");

	c_pass:  cover property (pass_done_q);
	c_latch: cover property (eval_en && set_act && !clr_act && !lat_cur);
	c_clear: cover property (eval_en && clr_act && lat_cur);
	c_write: cover property (wr_en && eq_hit);
endmodule

// ===== hw/lee_pkg.sv
// Package of constants and types for the logic equation engine
package lee_pkg;
	localparam int          LEE_SEL_W      = 9;
	localparam int          LEE_DLY_W      = 16;
	localparam int          LEE_NIN        = 4;
	localparam logic [11:0] LEE_CTRL_OFF   = 12'h000;
	localparam logic [11:0] LEE_STAT_OFF   = 12'h004;
	localparam logic [11:0] LEE_EQ_BASE    = 12'h100;
	localparam logic [2:0]  LEE_W_SEL01    = 3'h0;
	localparam logic [2:0]  LEE_W_SEL23    = 3'h1;
	localparam logic [2:0]  LEE_W_MISC     = 3'h2;
	localparam logic [2:0]  LEE_W_DLY      = 3'h3;
	localparam logic [2:0]  LEE_W_OBS      = 3'h4;
	localparam int          LEE_HI_LSB     = 16;
	localparam int          LEE_INV_LSB    = 9;
	localparam int          LEE_GATE_LSB   = 13;
	localparam int          LEE_SETINV_BIT = 15;
	localparam int          LEE_CLRINV_BIT = 16;
	localparam int          LEE_OBS_OUT    = 8;
	localparam int          LEE_PASS_LSB   = 16;
	localparam logic [2:0]  LEE_COUNT_RST  = 3'h3;
	localparam logic [6:0]  LEE_N0         = 7'h00;
	localparam logic [6:0]  LEE_N1         = 7'h05;
	localparam logic [6:0]  LEE_N2         = 7'h0A;
	localparam logic [6:0]  LEE_N3         = 7'h14;
	localparam logic [6:0]  LEE_N4         = 7'h28;
	localparam logic [6:0]  LEE_N5         = 7'h50;

	typedef enum logic [1:0] {LEE_AND, LEE_OR, LEE_NAND, LEE_NOR} lee_gate_type;

	typedef struct packed {
		logic [LEE_NIN-1:0][LEE_SEL_W-1:0] sel;
		logic [LEE_NIN-1:0]                inv;
		lee_gate_type                      gate;
		logic                              set_inv;
		logic [LEE_SEL_W-1:0]              clr_sel;
		logic                              clr_inv;
		logic [LEE_DLY_W-1:0]              on_dly;
		logic [LEE_DLY_W-1:0]              off_dly;
	} lee_cfg_type;

	typedef struct packed {
		logic [LEE_NIN-1:0] in_lvl;
		logic               clr_lvl;
	} lee_obs_type;

	localparam lee_cfg_type LEE_CFG_RST = '0;

	function automatic logic [6:0] lee_active_n(input logic [2:0] code);
		unique case (code)
			3'h0: lee_active_n = LEE_N0;
			3'h1: lee_active_n = LEE_N1;
			3'h2: lee_active_n = LEE_N2;
			3'h3: lee_active_n = LEE_N3;
			3'h4: lee_active_n = LEE_N4;
			3'h5: lee_active_n = LEE_N5;
			default: lee_active_n = LEE_N0;
		endcase
	endfunction
endpackage

// ===== sim/lee_relay_model.sv
// Relay signal source standing in front of the equation engine
`timescale 1ns/100ps
module lee_relay_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] level_req,
	output logic      [31:0] relay_signals
);
	// Registered so a level change lands one cycle after the bench asks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_signals <= 32'h0000_0000;
		end else begin
			relay_signals <= level_req;
		end
	end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the logic equation engine
`timescale 1ns/100ps
`define CHK(a, b, m) begin \
	total_checks++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("mismatch at %0t: %s", $time, m); \
	end \
end
module testbench;
	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] level_req;
	logic [31:0] relay_signals;
	logic [79:0] gate_result;
	logic [79:0] delayed_result;
	logic [79:0] latched_result;
	logic [79:0] latched_result_n;
	logic        pass_done;
	logic [31:0] rd;
	logic        err;
	int          n_mismatch;
	int          total_checks;
	int          cyc;
	int          np;

	always #4 pclk = ~pclk;

	lee_relay_model relay (.pclk(pclk), .presetn(presetn), .level_req(level_req), .relay_signals(relay_signals));
	lee_engine dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.relay_signals(relay_signals), .gate_result(gate_result), .delayed_result(delayed_result),
		.latched_result(latched_result), .latched_result_n(latched_result_n), .pass_done(pass_done));

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task timeout_hit;
		$display("mismatch at %0t: wait timed out", $time);
		n_mismatch++;
		end_sim();
	endtask

	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) timeout_hit();
	endtask

	function automatic logic [11:0] eq_addr(input int e, input logic [2:0] w);
		eq_addr = lee_pkg::LEE_EQ_BASE + 12'(e * 32) + 12'(w * 4);
	endfunction

	function automatic logic [31:0] pair(input logic [8:0] lo, input logic [8:0] hi);
		pair = 32'(lo) | (32'(hi) << lee_pkg::LEE_HI_LSB);
	endfunction

	function automatic logic [31:0] misc(input logic [8:0] c, input logic [3:0] iv, input logic [1:0] g,
		input logic si, input logic ci);
		misc = 32'(c) | (32'(iv) << lee_pkg::LEE_INV_LSB) | (32'(g) << lee_pkg::LEE_GATE_LSB)
			| (32'(si) << lee_pkg::LEE_SETINV_BIT) | (32'(ci) << lee_pkg::LEE_CLRINV_BIT);
	endfunction

	task cfg(input int e, input logic [31:0] s01, input logic [31:0] s23, input logic [31:0] m,
		input logic [31:0] dly);
		apb(1'b1, eq_addr(e, lee_pkg::LEE_W_SEL01), s01);
		apb(1'b1, eq_addr(e, lee_pkg::LEE_W_SEL23), s23);
		apb(1'b1, eq_addr(e, lee_pkg::LEE_W_MISC), m);
		apb(1'b1, eq_addr(e, lee_pkg::LEE_W_DLY), dly);
	endtask

	task passes(input int n);
		int k;
		int i;
		k = 0;
		for (i = 0; i < 2000 && k < n; i++) begin
			@(posedge pclk);
			if (pass_done === 1'b1) k++;
		end
		if (k < n) timeout_hit();
	endtask

	function automatic logic out_bit(input int k);
		case (k)
			0: out_bit = gate_result[0];
			1: out_bit = delayed_result[0];
			default: out_bit = gate_result[1];
		endcase
	endfunction

	// Counts edges and pass pulses until the chosen output shows v
	task wait_out(input int k, input logic v);
		cyc = 0;
		np = 0;
		while (out_bit(k) !== v || cyc == 0) begin
			@(posedge pclk);
			cyc++;
			if (out_bit(k) === v) break;
			if (pass_done === 1'b1) np++;
			if (cyc > 3000) timeout_hit();
		end
	endtask

	task t_reset;
		`CHK(gate_result | delayed_result | latched_result, 80'h0, "outputs not clear")
		apb(1'b0, lee_pkg::LEE_CTRL_OFF, 32'h0);
		`CHK(rd[2:0], 3'h3, "count reset")
		apb(1'b0, eq_addr(0, 3'h5), 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0}, "unmapped access")
		// After one full pass only the twenty default equations show an inverted latch
		passes(1);
		`CHK(latched_result_n, {60'h0, 20'hF_FFFF}, "inverted latch after pass")
		$display("test reset done");
	endtask

	task t_count;
		int n_tab [8] = '{0, 5, 10, 20, 40, 80, 0, 0};
		int i;
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, lee_pkg::LEE_CTRL_OFF, 32'(c));
			repeat (200) @(posedge pclk);
			cyc = 0;
			np = 0;
			for (i = 0; i < 200 && np < 2; i++) begin
				@(posedge pclk);
				if (np == 1) cyc++;
				if (pass_done === 1'b1) np++;
			end
			`CHK(cyc, n_tab[c], "pass length")
		end
		// Five equations keep every later pass short
		apb(1'b1, lee_pkg::LEE_CTRL_OFF, 32'h1);
		$display("test count done");
	endtask

	task t_gate;
		logic e;
		cfg(0, pair(9'h1, 9'h2), 32'h0, 32'h0, 32'h0);
		for (int g = 0; g < 4; g++) begin
			for (int r = 0; r < 4; r++) begin
				level_req <= 32'(r);
				// Invert bits on the two unassigned inputs must change nothing
				apb(1'b1, eq_addr(0, lee_pkg::LEE_W_MISC), misc(9'h0, 4'hE, 2'(g), 1'b0, 1'b0));
				passes(2);
				e = ((g % 2) ? (r[0] | ~r[1]) : (r[0] & ~r[1])) ^ 1'(g / 2);
				`CHK(gate_result[0], e, "gate result")
				apb(1'b0, eq_addr(0, lee_pkg::LEE_W_OBS), 32'h0);
				`CHK({rd[8], rd[2:1], rd[0]}, {e, 2'(r), 1'b0}, "observed levels")
			end
		end
		// Nothing assigned: inverts set and a NAND gate must still give a low result
		apb(1'b1, eq_addr(2, lee_pkg::LEE_W_MISC), misc(9'h0, 4'hF, 2'h2, 1'b0, 1'b0));
		passes(2);
		`CHK(gate_result[2], 1'b0, "unassigned inputs")
		$display("test gate done");
	endtask

	task t_timer;
		level_req <= 32'h2;
		cfg(0, pair(9'h1, 9'h0), 32'h0, misc(9'h2, 4'h0, 2'h1, 1'b0, 1'b0), 32'h0002_0003);
		passes(3);
		`CHK(latched_result[0], 1'b0, "latch not cleared")
		level_req <= 32'h1;
		wait_out(0, 1'b1);
		wait_out(1, 1'b1);
		`CHK(np, 3, "assert delay")
		`CHK({latched_result[0], latched_result_n[0]}, 2'b10, "latch set")
		level_req <= 32'h0;
		wait_out(0, 1'b0);
		wait_out(1, 1'b0);
		`CHK(np, 2, "deassert delay")
		`CHK(latched_result[0], 1'b1, "latch not held")
		level_req <= 32'h2;
		passes(2);
		`CHK({latched_result[0], latched_result_n[0]}, 2'b01, "latch not cleared")
		apb(1'b1, eq_addr(0, lee_pkg::LEE_W_MISC), misc(9'h2, 4'h0, 2'h1, 1'b1, 1'b1));
		passes(2);
		`CHK(latched_result[0], 1'b1, "inverted set")
		level_req <= 32'h0;
		passes(2);
		`CHK(latched_result[0], 1'b0, "inverted clear")
		$display("test timer done");
	endtask

	task t_cascade;
		level_req <= 32'h0;
		cfg(0, pair(9'h1, 9'h0), 32'h0, misc(9'h0, 4'h0, 2'h1, 1'b0, 1'b0), 32'h0);
		cfg(1, pair(9'd33, 9'h0), 32'h0, misc(9'h0, 4'h0, 2'h1, 1'b0, 1'b0), 32'h0);
		passes(2);
		level_req <= 32'h1;
		wait_out(0, 1'b1);
		wait_out(2, 1'b1);
		`CHK(cyc, 1, "ascending cascade")
		`CHK(np, 0, "ascending pass count")
		level_req <= 32'h0;
		apb(1'b1, eq_addr(0, lee_pkg::LEE_W_SEL01), pair(9'd37, 9'h0));
		apb(1'b1, eq_addr(1, lee_pkg::LEE_W_SEL01), pair(9'h3, 9'h0));
		passes(3);
		level_req <= 32'h4;
		wait_out(2, 1'b1);
		wait_out(0, 1'b1);
		`CHK(cyc, 4, "descending cascade")
		`CHK(np, 1, "descending pass count")
		$display("test cascade done");
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		level_req = 32'h0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_count();
		t_gate();
		t_timer();
		t_cascade();
		end_sim();
	end
endmodule
